// >>> design/torque_limit_select.sv
// torque limit selection and clamping with limiting-active status
// ------------------------------------------------------------
// Summary of operation
// - forward and reverse torque always clamped to internal limits
// - limit settings 0..800 percent, immediate effect, internal default 800
// - external limit settings default 100, range 0..800, immediate effect
// - limit above motor maximum torque is replaced by motor maximum
// - forward input closed: forward limit is min of internal and external
// - forward input open: forward limit is internal setting only
// - reverse input closed: reverse limit is min of internal and external
// - reverse input open: reverse limit is internal setting only
// - external inputs recognised only when allocated in input allocation
// - limiting-active output on while torque is clamped, else off
// - limiting-active reaches pin only when allocated in output allocation
// - command limits, gated by option request bits when enabled, also tighten the limit
// ------------------------------------------------------------
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module torque_limit_select
   import torque_limit_pkg::*;
#(
   parameter int TW = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire torque_limit_pkg::reg_req_s i_req,
   output logic [torque_limit_pkg::DATA_W-1:0] o_rdata,
   input wire logic signed [TW-1:0] i_torque_demand,
   input wire logic i_fwd_ext_limit_in,
   input wire logic i_rev_ext_limit_in,
   output logic signed [TW-1:0] o_torque_out,
   output logic o_limiting_active_out
);
   import torque_limit_pkg::*;

   // ------------------------------------------------------------
   // settings
   // ------------------------------------------------------------
   logic [DATA_W-1:0] fwd_torque_limit_ff;
   logic [DATA_W-1:0] rev_torque_limit_ff;
   logic [DATA_W-1:0] fwd_ext_torque_limit_ff;
   logic [DATA_W-1:0] rev_ext_torque_limit_ff;
   logic [DATA_W-1:0] motor_max_ff;
   logic [2:0] alloc_ff;
   logic [2:0] option_ff;
   limit_pair_s cmd_limit_ff;
   logic [DATA_W-1:0] status_w;
   limit_pair_s eff_w;

   // out-of-range writes saturate to the top of the range
   function automatic logic [DATA_W-1:0] sat_limit(input logic [DATA_W-1:0] v);
      if (v > LIMIT_MAX) begin
         return LIMIT_MAX;
      end
      return v;
   endfunction

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         fwd_torque_limit_ff <= RST_INT_LIMIT;
         rev_torque_limit_ff <= RST_INT_LIMIT;
         fwd_ext_torque_limit_ff <= RST_EXT_LIMIT;
         rev_ext_torque_limit_ff <= RST_EXT_LIMIT;
         motor_max_ff <= RST_MOTOR_MAX;
         alloc_ff <= 3'h0;
         option_ff <= 3'h0;
         cmd_limit_ff <= '{fwd: RST_CMD_LIMIT, rev: RST_CMD_LIMIT};
      end else if (i_req.wr) begin
         case (i_req.addr)
            OFS_FWD_LIMIT: fwd_torque_limit_ff <= sat_limit(i_req.wdata);
            OFS_REV_LIMIT: rev_torque_limit_ff <= sat_limit(i_req.wdata);
            OFS_FWD_EXT_LIMIT: fwd_ext_torque_limit_ff <= sat_limit(i_req.wdata);
            OFS_REV_EXT_LIMIT: rev_ext_torque_limit_ff <= sat_limit(i_req.wdata);
            OFS_MOTOR_MAX: motor_max_ff <= sat_limit(i_req.wdata);
            OFS_ALLOC: alloc_ff <= i_req.wdata[2:0];
            OFS_CMD_FWD: cmd_limit_ff.fwd <= sat_limit(i_req.wdata);
            OFS_CMD_REV: cmd_limit_ff.rev <= sat_limit(i_req.wdata);
            OFS_OPTION: option_ff <= i_req.wdata[2:0];
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // effective limits
   // ------------------------------------------------------------
   logic fwd_in_on;
   logic rev_in_on;
   logic fwd_cmd_on;
   logic rev_cmd_on;

   // unallocated inputs read as open
   assign fwd_in_on = alloc_ff[ALLOC_FWD_IN_BIT] & i_fwd_ext_limit_in;
   assign rev_in_on = alloc_ff[ALLOC_REV_IN_BIT] & i_rev_ext_limit_in;
   // command limit alone, or gated by option request bit when enabled
   assign fwd_cmd_on = ~option_ff[OPT_CMD_EN_BIT] | option_ff[OPT_FWD_BIT];
   assign rev_cmd_on = ~option_ff[OPT_CMD_EN_BIT] | option_ff[OPT_REV_BIT];

   limit_min3 #(.W(DATA_W)) u_fwd_limit (
      .i_internal(fwd_torque_limit_ff),
      .i_external(fwd_ext_torque_limit_ff),
      .i_ext_on(fwd_in_on),
      .i_command(cmd_limit_ff.fwd),
      .i_cmd_on(fwd_cmd_on),
      .i_motor_max(motor_max_ff),
      .o_limit(eff_w.fwd)
   );

   limit_min3 #(.W(DATA_W)) u_rev_limit (
      .i_internal(rev_torque_limit_ff),
      .i_external(rev_ext_torque_limit_ff),
      .i_ext_on(rev_in_on),
      .i_command(cmd_limit_ff.rev),
      .i_cmd_on(rev_cmd_on),
      .i_motor_max(motor_max_ff),
      .o_limit(eff_w.rev)
   );

   // ------------------------------------------------------------
   // clamp
   // ------------------------------------------------------------
   logic signed [TW:0] dem_ext;
   logic signed [TW:0] fwd_lim_s;
   logic signed [TW:0] rev_lim_s;
   logic signed [TW-1:0] nxt_torque;
   logic nxt_fwd_clamp;
   logic nxt_rev_clamp;

   always_comb begin
      dem_ext = (TW+1)'(i_torque_demand);
      fwd_lim_s = $signed({1'b0, TW'(eff_w.fwd)});
      rev_lim_s = -$signed({1'b0, TW'(eff_w.rev)});
      nxt_torque = i_torque_demand;
      nxt_fwd_clamp = 1'b0;
      nxt_rev_clamp = 1'b0;
      if (dem_ext > fwd_lim_s) begin
         nxt_torque = TW'(fwd_lim_s);
         nxt_fwd_clamp = 1'b1;
      end else if (dem_ext < rev_lim_s) begin
         nxt_torque = TW'(rev_lim_s);
         nxt_rev_clamp = 1'b1;
      end
   end

   logic fwd_clamp_ff;
   logic rev_clamp_ff;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_torque_out <= '0;
         fwd_clamp_ff <= 1'b0;
         rev_clamp_ff <= 1'b0;
      end else begin
         o_torque_out <= nxt_torque;
         fwd_clamp_ff <= nxt_fwd_clamp;
         rev_clamp_ff <= nxt_rev_clamp;
      end
   end

   // status pin follows the clamp in the same cycle as the clamped torque
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_limiting_active_out <= 1'b0;
      end else begin
         o_limiting_active_out <= alloc_ff[ALLOC_OUT_BIT] & (nxt_fwd_clamp | nxt_rev_clamp);
      end
   end

   // ------------------------------------------------------------
   // read back
   // ------------------------------------------------------------
   always_comb begin
      status_w = '0;
      status_w[STS_LIMITING_BIT] = fwd_clamp_ff | rev_clamp_ff;
      status_w[STS_FWD_CLAMP_BIT] = fwd_clamp_ff;
      status_w[STS_REV_CLAMP_BIT] = rev_clamp_ff;
      status_w[STS_FWD_IN_BIT] = fwd_in_on;
      status_w[STS_REV_IN_BIT] = rev_in_on;
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_rdata <= '0;
      end else if (i_req.rd) begin
         case (i_req.addr)
            OFS_FWD_LIMIT: o_rdata <= fwd_torque_limit_ff;
            OFS_REV_LIMIT: o_rdata <= rev_torque_limit_ff;
            OFS_FWD_EXT_LIMIT: o_rdata <= fwd_ext_torque_limit_ff;
            OFS_REV_EXT_LIMIT: o_rdata <= rev_ext_torque_limit_ff;
            OFS_MOTOR_MAX: o_rdata <= motor_max_ff;
            OFS_ALLOC: o_rdata <= {13'h0000, alloc_ff};
            OFS_CMD_FWD: o_rdata <= cmd_limit_ff.fwd;
            OFS_CMD_REV: o_rdata <= cmd_limit_ff.rev;
            OFS_OPTION: o_rdata <= {13'h0000, option_ff};
            OFS_STATUS: o_rdata <= status_w;
            OFS_EFF_FWD: o_rdata <= eff_w.fwd;
            OFS_EFF_REV: o_rdata <= eff_w.rev;
            default: o_rdata <= '0;
         endcase
      end else begin
         o_rdata <= '0;
      end
   end

endmodule

// >>> design/torque_limit_pkg.sv
// package: register map, field layout, reset values and carriers of the torque limiter
package torque_limit_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int TRQ_W = 16;

   // register offsets
   localparam logic [7:0] OFS_FWD_LIMIT = 8'h00;
   localparam logic [7:0] OFS_REV_LIMIT = 8'h04;
   localparam logic [7:0] OFS_FWD_EXT_LIMIT = 8'h08;
   localparam logic [7:0] OFS_REV_EXT_LIMIT = 8'h0c;
   localparam logic [7:0] OFS_MOTOR_MAX = 8'h10;
   localparam logic [7:0] OFS_ALLOC = 8'h14;
   localparam logic [7:0] OFS_CMD_FWD = 8'h18;
   localparam logic [7:0] OFS_CMD_REV = 8'h1c;
   localparam logic [7:0] OFS_OPTION = 8'h20;
   localparam logic [7:0] OFS_STATUS = 8'h24;
   localparam logic [7:0] OFS_EFF_FWD = 8'h28;
   localparam logic [7:0] OFS_EFF_REV = 8'h2c;

   // reset values and top of the limit range
   localparam logic [15:0] RST_INT_LIMIT = 16'h0320;
   localparam logic [15:0] RST_EXT_LIMIT = 16'h0064;
   localparam logic [15:0] RST_MOTOR_MAX = 16'h0320;
   localparam logic [15:0] RST_CMD_LIMIT = 16'h0320;
   localparam logic [15:0] LIMIT_MAX = 16'h0320;

   // allocation register fields
   localparam int ALLOC_FWD_IN_BIT = 0;
   localparam int ALLOC_REV_IN_BIT = 1;
   localparam int ALLOC_OUT_BIT = 2;

   // option register fields
   localparam int OPT_CMD_EN_BIT = 0;
   localparam int OPT_FWD_BIT = 1;
   localparam int OPT_REV_BIT = 2;

   // status register fields
   localparam int STS_LIMITING_BIT = 0;
   localparam int STS_FWD_CLAMP_BIT = 1;
   localparam int STS_REV_CLAMP_BIT = 2;
   localparam int STS_FWD_IN_BIT = 3;
   localparam int STS_REV_IN_BIT = 4;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef struct packed {
      logic [DATA_W-1:0] fwd;
      logic [DATA_W-1:0] rev;
   } limit_pair_s;

endpackage

// >>> design/limit_min3.sv
// effective limit for one direction: min of enabled sources, capped at motor max
`timescale 1ns/1ps
module limit_min3 #(
   parameter int W = 16
) (
   input wire logic [W-1:0] i_internal,
   input wire logic [W-1:0] i_external,
   input wire logic i_ext_on,
   input wire logic [W-1:0] i_command,
   input wire logic i_cmd_on,
   input wire logic [W-1:0] i_motor_max,
   output logic [W-1:0] o_limit
);
   logic [W-1:0] a;
   logic [W-1:0] b;

   always_comb begin
      a = i_internal;
      // external setting only tightens while its input is closed
      if (i_ext_on && (i_external < a)) begin
         a = i_external;
      end
      b = a;
      if (i_cmd_on && (i_command < b)) begin
         b = i_command;
      end
      if (b > i_motor_max) begin
         b = i_motor_max;
      end
      o_limit = b;
   end
endmodule

// >>> verification/torque_limit_select_checker.sv
// checker: port-level assertions of the torque limiter
`timescale 1ns/1ps
module torque_limit_select_checker
   import torque_limit_pkg::*;
#(
   parameter int TW = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire torque_limit_pkg::reg_req_s i_req,
   input wire logic [torque_limit_pkg::DATA_W-1:0] o_rdata,
   input wire logic signed [TW-1:0] i_torque_demand,
   input wire logic i_fwd_ext_limit_in,
   input wire logic i_rev_ext_limit_in,
   input wire logic signed [TW-1:0] o_torque_out,
   input wire logic o_limiting_active_out
);
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rstn);
   // inputs and settings unchanged over the last cycle
   sequence s_quiet;
      $past(i_rstn) && !$past(i_req.wr) && $stable(i_torque_demand)
         && $stable(i_fwd_ext_limit_in) && $stable(i_rev_ext_limit_in);
   endsequence
   property p_cap;
      o_torque_out <= 16'sh0320 && o_torque_out >= -16'sh0320;
   endproperty
   a_cap: assert property (p_cap) else $error("torque beyond cap");
   property p_fwd_sat;
      $past(i_rstn) && $past(i_torque_demand) >= 0
         |-> o_torque_out >= 0 && o_torque_out <= $past(i_torque_demand);
   endproperty
   a_fwd_sat: assert property (p_fwd_sat) else $error("fwd saturation");
   property p_rev_sat;
      $past(i_rstn) && $past(i_torque_demand) < 0
         |-> o_torque_out <= 0 && o_torque_out >= $past(i_torque_demand);
   endproperty
   a_rev_sat: assert property (p_rev_sat) else $error("rev saturation");
   property p_lim_cause;
      o_limiting_active_out |-> o_torque_out != $past(i_torque_demand);
   endproperty
   a_lim_cause: assert property (p_lim_cause) else $error("flag without clamp");
   property p_lim_dir;
      o_limiting_active_out && $past(i_torque_demand) > 0 |-> o_torque_out < $past(i_torque_demand);
   endproperty
   a_lim_dir: assert property (p_lim_dir) else $error("flag on wrong side");
   property p_zero;
      $past(i_rstn) && $past(i_torque_demand) == 0 |-> o_torque_out == 0 && !o_limiting_active_out;
   endproperty
   a_zero: assert property (p_zero) else $error("zero demand altered");
   property p_rd_idle;
      !$past(i_req.rd) |-> o_rdata == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
   property p_steady;
      s_quiet |=> $stable(o_torque_out) && $stable(o_limiting_active_out);
   endproperty
   a_steady: assert property (p_steady) else $error("output moved while quiet");
endmodule

bind torque_limit_select torque_limit_select_checker #(.TW(TW)) chk_u (
   .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_req(i_req), .o_rdata(o_rdata),
   .i_torque_demand(i_torque_demand), .i_fwd_ext_limit_in(i_fwd_ext_limit_in),
   .i_rev_ext_limit_in(i_rev_ext_limit_in), .o_torque_out(o_torque_out),
   .o_limiting_active_out(o_limiting_active_out));

// >>> verification/host_limit_model.sv
// host controller model: drives the discrete limit inputs
`timescale 1ns/1ps
module host_limit_model (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_fwd_req,
   input wire logic i_rev_req,
   output logic o_fwd_ext_limit_in,
   output logic o_rev_ext_limit_in
);
   // inputs close only during phases where reduced torque is asked for
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_fwd_ext_limit_in <= 1'b0;
         o_rev_ext_limit_in <= 1'b0;
      end else begin
         o_fwd_ext_limit_in <= i_fwd_req;
         o_rev_ext_limit_in <= i_rev_req;
      end
   end
endmodule

// >>> verification/tb_torque_limit_select.sv
// testbench of the torque limiter
`timescale 1ns/1ps
module tb_torque_limit_select;
   import torque_limit_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   reg_req_s req = '0;
   logic signed [15:0] dem = '0;
   logic fwd_req = 1'b0;
   logic rev_req = 1'b0;
   logic fwd_in, rev_in, lim;
   logic [15:0] rdata, lf, lr, v;
   logic signed [15:0] tout, e;
   logic [7:0] a;
   int n_fail = 0;
   int n_checks = 0;
   int cycles = 0;
   int seed = 32'h75b9;
   logic [15:0] r [0:8];
   torque_limit_select dut_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_req(req),
      .o_rdata(rdata), .i_torque_demand(dem), .i_fwd_ext_limit_in(fwd_in),
      .i_rev_ext_limit_in(rev_in), .o_torque_out(tout), .o_limiting_active_out(lim));
   host_limit_model host_u (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_fwd_req(fwd_req),
      .i_rev_req(rev_req), .o_fwd_ext_limit_in(fwd_in), .o_rev_ext_limit_in(rev_in));
   initial forever #20 i_clk_sys = ~i_clk_sys;
   always @(posedge i_clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] ad, input logic [15:0] d);
      @(posedge i_clk_sys);
      req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk_sys);
      req.wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] ad, input logic [15:0] x);
      @(posedge i_clk_sys);
      req <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk_sys);
      req.rd <= 1'b0;
      #1 chk16(rdata, x);
   endtask
   // limit of one direction from the mirrored settings
   function automatic logic [15:0] eff(input int dir, input logic on);
      logic [15:0] l;
      l = r[dir];
      if (on && r[5][dir] && r[2+dir] < l) l = r[2+dir];
      if ((!r[8][0] || r[8][1+dir]) && r[6+dir] < l) l = r[6+dir];
      if (r[4] < l) l = r[4];
      return l;
   endfunction
   initial begin
      r = '{16'h0320, 16'h0320, 16'h0064, 16'h0064, 16'h0320, 16'h0, 16'h0320, 16'h0320, 16'h0};
      repeat (2) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      for (int i = 0; i < 9; i++) rd_reg(8'(i * 4), r[i]);
      wr_reg(8'h00, 16'h0385);
      rd_reg(8'h00, 16'h0320);
      wr_reg(8'h30, 16'hffff);
      rd_reg(8'h30, 16'h0000);
      for (int i = 0; i < 3000; i++) begin
         a = 8'(($unsigned($random(seed)) % 9) * 4);
         v = (a == 8'h14 || a == 8'h20) ? 16'($unsigned($random(seed)) % 8)
            : 16'($unsigned($random(seed)) % (a < 8'h10 ? 901 : 801));
         r[a/4] = (a < 8'h10 && v > 16'h0320) ? 16'h0320 : v;
         wr_reg(a, v);
         // corner cases: demand equal to the internal forward limit setting, and the most negative demand
         dem <= (i % 5 == 0) ? r[0] : (i % 7 == 0) ? 16'h8000 : 16'($random(seed) % 1001);
         fwd_req <= 1'($random(seed));
         rev_req <= 1'($random(seed));
         // one edge for the host to pass the inputs on, one for the clamp
         repeat (2) @(posedge i_clk_sys);
         #1;
         lf = eff(0, fwd_req);
         lr = eff(1, rev_req);
         e = (dem > $signed({1'b0, lf})) ? lf : (dem < -$signed({1'b0, lr})) ? -lr : dem;
         chk16(tout, e);
         chk1(lim, (e != dem) & r[5][2]);
         if (i % 8 == 0) begin
            rd_reg(OFS_EFF_FWD, lf);
            rd_reg(OFS_EFF_REV, lr);
            v = {11'h000, r[5][1] & rev_req, r[5][0] & fwd_req,
               dem < -$signed({1'b0, lr}), dem > $signed({1'b0, lf}), e != dem};
            rd_reg(OFS_STATUS, v);
         end
      end
      report_and_stop();
   end
endmodule
